// ### rtl/sbs_free_timer.sv
// free-bus timeout: bit-rate source selection and high-level period counter
`timescale 1ns/1ps
module sbs_free_timer
    import sbs_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [3:0] timer_ovf_in,
    input  wire logic [1:0] src_sel_in,
    input  wire logic       enable_in,
    input  wire logic       bus_high_in,
    output logic            free_out
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       tick;
    logic       hit;

    // selected overflow: 0 t0, 1 t1, 2 t2 high, 3 t2 low
    assign tick    = timer_ovf_in[src_sel_in];
    assign hit     = (cnt_r == FREE_PERIODS) && tick;
    assign cnt_nxt = (!enable_in || !bus_high_in) ? 4'h0 :
                     (tick && cnt_r <= FREE_PERIODS) ? cnt_r + 4'h1 : cnt_r;

    // count periods with both lines high; fire once past ten
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r    <= 4'h0;
            free_out <= 1'b0;
        end
        else
        begin
            cnt_r    <= cnt_nxt;
            free_out <= enable_in && bus_high_in && hit;
        end
    end
endmodule

// ### rtl/sbs_pkg.sv
// package: register map, field layout and codes of the two-wire slave status block
package sbs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL  = 8'hc0;
    localparam logic [7:0] IDX_CONFIG   = 8'hc1;
    localparam logic [7:0] IDX_DATA     = 8'hc2;
    localparam logic [7:0] IDX_OWN_ADDR = 8'hc3;
    localparam logic [7:0] IDX_VECTOR   = 8'hc4;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hc5;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hc6;
    localparam int         ADR_W        = 10;
    // control register bit positions
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_ACK_REQUEST_FLAG = 3;
    localparam int CTL_ARB   = 2;
    localparam int CTL_ACK   = 1;
    localparam int CTL_SI    = 0;
    // configuration register bit 5 is read-only busy
    localparam int         CFG_BUSY     = 5;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] CFG_WR_MASK  = 8'hdf;
    localparam logic [6:0] OWN_ADDR_RST = 7'h00;
    // status vectors
    localparam logic [3:0] VEC_DATA = 4'h0;
    localparam logic [3:0] VEC_STOP = 4'h1;
    localparam logic [3:0] VEC_ADDR = 4'h2;
    // kinds of arbitration loss reported by the master engine
    localparam logic [1:0] LOST_DATA   = 2'h0;
    localparam logic [1:0] LOST_RSTART = 2'h1;
    localparam logic [1:0] LOST_DETSTP = 2'h2;
    localparam logic [1:0] LOST_TRYSTP = 2'h3;
    // interrupt status bits
    localparam int IRQ_UPDATE = 0;
    localparam int IRQ_ARB    = 1;
    localparam int IRQ_STOP   = 2;
    localparam int IRQ_W      = 3;
    // bits per byte and free-bus periods
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] FREE_PERIODS = 4'ha;

    typedef struct packed {
        logic       enable;
        logic       inhibit;
        logic       busy;
        logic       ext_hold;
        logic       lto_en;
        logic       fto_en;
        logic [1:0] src_sel;
    } sbs_cfg_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } sbs_pins_type;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_DATA     = 3'b011,
        ST_DATA_ACK = 3'b100,
        ST_SKIP     = 3'b101
    } sbs_state_type;
endpackage

// ### rtl/sbs_slave_status.sv
// two-wire slave receiver status, arbitration-loss status and configuration
`timescale 1ns/1ps
module sbs_slave_status
    import sbs_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [ADR_W-1:0]  wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe_out,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    input  wire logic [3:0]        timer_ovf_in,
    input  wire logic              lost_in,
    input  wire logic [1:0]        lost_kind_in,
    output logic                   start_request_out,
    output logic                   stop_request_out,
    output logic                   irq_out
);
    sbs_pins_type  meta_r;
    sbs_pins_type  pin_r;
    sbs_pins_type  prev_r;
    sbs_cfg_type   cfg_r;
    sbs_state_type state_r;
    sbs_state_type state_nxt;
    logic [7:0]        shift_r;
    logic [3:0]        cnt_r;
    logic [7:0]        data_r;
    logic [6:0]        own_r;
    logic [3:0]        vec_r;
    logic              si_r;
    logic              arb_r;
    logic              ack_r;
    logic              lost_pend_r;
    logic              busy_r;
    logic              rw_r;
    logic [IRQ_W-1:0]  ist_r;
    logic [IRQ_W-1:0]  imask_r;
    logic              free_pulse;

    // bus decode
    wire              req      = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire              wr_lo    = req && wb_we_in && wb_sel_in[0];
    wire [7:0]        idx      = wb_adr_in[ADR_W-1:2];
    wire              hit_ctl  = (idx == IDX_CONTROL);
    wire              hit_cfg  = (idx == IDX_CONFIG);
    wire              hit_dat  = (idx == IDX_DATA);
    wire              hit_own  = (idx == IDX_OWN_ADDR);
    wire              hit_vec  = (idx == IDX_VECTOR);
    wire              hit_ist  = (idx == IDX_IRQ_STAT);
    wire              hit_imk  = (idx == IDX_IRQ_MASK);
    wire              wr_ctl   = wr_lo && hit_ctl;
    wire [7:0]        wd       = wb_dat_in[7:0];

    // line events seen on synchronised pins
    wire              on       = cfg_r.enable;
    wire              scl_rise = on && pin_r.scl && !prev_r.scl;
    wire              scl_fall = on && !pin_r.scl && prev_r.scl;
    wire              start_d  = on && pin_r.scl && prev_r.scl && !pin_r.sda && prev_r.sda;
    wire              stop_d   = on && pin_r.scl && prev_r.scl && pin_r.sda && !prev_r.sda;
    wire              addressed = (state_r != ST_IDLE) && (state_r != ST_ADDR);
    wire              byte_end = scl_fall && (cnt_r == BYTE_BITS);
    wire              match    = (shift_r[7:1] == own_r) && !cfg_r.inhibit;
    wire              addr_hit = (state_r == ST_ADDR) && byte_end && match;
    wire              data_end = (state_r == ST_DATA) && byte_end;
    wire              stop_ev  = stop_d && addressed && !cfg_r.inhibit;
    wire              lost_ev  = on && lost_in;
    wire              upd      = lost_ev || addr_hit || data_end || stop_ev;

    // read value of the control register; request flag is hard zero
    wire [7:0]        ctl_rd   = {2'b00, start_request_out, stop_request_out,
                                  1'b0, arb_r, ack_r, si_r};
    wire [7:0]        cfg_rd   = {cfg_r[7:6], busy_r, cfg_r[4:0]};
    wire [7:0]        rd_byte  = hit_ctl ? ctl_rd :
                                 hit_cfg ? cfg_rd :
                                 hit_dat ? data_r :
                                 hit_own ? {1'b0, own_r} :
                                 hit_vec ? {4'h0, vec_r} :
                                 hit_ist ? {5'h00, ist_r} :
                                 hit_imk ? {5'h00, imask_r} : 8'h00;

    // interrupt status: hardware set wins over write-one-clear
    wire [IRQ_W-1:0]  ist_set  = {stop_ev, lost_ev, upd};
    wire [IRQ_W-1:0]  ist_clr  = (wr_lo && hit_ist) ? wd[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0]  ist_nxt  = (ist_r & ~ist_clr) | ist_set;

    // status vector for the event of this cycle
    function automatic logic [3:0] lost_vec(input logic [1:0] kind);
        case (kind)
            LOST_DATA:   lost_vec = VEC_DATA;
            LOST_RSTART: lost_vec = VEC_ADDR;
            default:     lost_vec = VEC_STOP;
        endcase
    endfunction

    // two-flop synchroniser, then previous sample for edge finding
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '1;
            pin_r  <= '1;
            prev_r <= '1;
        end
        else
        begin
            meta_r <= '{scl: scl_in, sda: sda_in};
            pin_r  <= meta_r;
            prev_r <= pin_r;
        end
    end

    // wishbone slave: one-cycle answer, unmapped reads zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_out <= req;
            wb_dat_out <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // software registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_r   <= sbs_cfg_type'(CFG_RESET);
            own_r   <= OWN_ADDR_RST;
            imask_r <= '0;
            ist_r   <= '0;
            irq_out <= 1'b0;
        end
        else
        begin
            if (wr_lo && hit_cfg)
                cfg_r <= sbs_cfg_type'((wd & CFG_WR_MASK) | (cfg_r & ~CFG_WR_MASK));
            if (wr_lo && hit_own)
                own_r <= wd[6:0];
            if (wr_lo && hit_imk)
                imask_r <= wd[IRQ_W-1:0];
            ist_r   <= ist_nxt;
            irq_out <= |(ist_nxt & imask_r);
        end
    end

    // control bits; a hardware update wins over a software clear
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            si_r              <= 1'b0;
            ack_r             <= 1'b0;
            start_request_out <= 1'b0;
            stop_request_out  <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                ack_r             <= wd[CTL_ACK];
                start_request_out <= wd[CTL_START];
                stop_request_out  <= wd[CTL_STOP];
            end
            si_r <= upd || (wr_ctl ? wd[CTL_SI] : si_r);
        end
    end

    // status vector, arbitration flag and lost-arbitration memory
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vec_r       <= VEC_DATA;
            arb_r       <= 1'b0;
            lost_pend_r <= 1'b0;
        end
        else if (lost_ev)
        begin
            vec_r       <= lost_vec(lost_kind_in);
            arb_r       <= 1'b1;
            lost_pend_r <= 1'b1;
        end
        else if (addr_hit)
        begin
            vec_r <= VEC_ADDR;
            arb_r <= lost_pend_r;
        end
        else if (data_end)
        begin
            vec_r <= VEC_DATA;
            arb_r <= 1'b0;
        end
        else if (stop_ev)
        begin
            vec_r       <= VEC_STOP;
            arb_r       <= 1'b0;
            lost_pend_r <= 1'b0;
        end
    end

    // busy: set by start, cleared by stop or free timeout
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            busy_r <= 1'b0;
        else if (!on || stop_d || free_pulse)
            busy_r <= 1'b0;
        else if (start_d)
            busy_r <= 1'b1;
    end

    // receive sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:     state_nxt = ST_IDLE;
            ST_ADDR:     if (byte_end) state_nxt = match ? ST_ADDR_ACK : ST_IDLE;
            ST_ADDR_ACK: if (scl_fall) state_nxt = rw_r ? ST_SKIP : ST_DATA;
            ST_DATA:     if (byte_end) state_nxt = ST_DATA_ACK;
            ST_DATA_ACK: if (scl_fall) state_nxt = ST_DATA;
            ST_SKIP:     state_nxt = ST_SKIP;
            default:     state_nxt = ST_IDLE;
        endcase
        if (stop_d)
            state_nxt = ST_IDLE;
        if (start_d)
            state_nxt = ST_ADDR;
        if (!on)
            state_nxt = ST_IDLE;
    end

    // shifter, bit count and acknowledge drive
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r    <= ST_IDLE;
            shift_r    <= 8'h00;
            cnt_r      <= 4'h0;
            data_r     <= 8'h00;
            rw_r       <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (start_d || byte_end)
                cnt_r <= 4'h0;
            else if (scl_rise && (state_r == ST_ADDR || state_r == ST_DATA))
            begin
                shift_r <= {shift_r[6:0], pin_r.sda};
                cnt_r   <= cnt_r + 4'h1;
            end
            if (addr_hit)
                rw_r <= shift_r[0];
            if (data_end)
                data_r <= shift_r;
            // matching address byte always acknowledged; data byte acknowledge uses the preset acknowledge bit
            if (!on || start_d || stop_d)
                sda_oe_out <= 1'b0;
            else if (addr_hit)
                sda_oe_out <= 1'b1;
            else if (data_end)
                sda_oe_out <= ack_r;
            else if (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_DATA_ACK))
                sda_oe_out <= 1'b0;
        end
    end

    // open-drain outputs: clock held low while the flag stands
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_out    <= 1'b0;
            sda_out    <= 1'b0;
            scl_oe_out <= 1'b0;
        end
        else
        begin
            scl_out    <= 1'b0;
            sda_out    <= 1'b0;
            scl_oe_out <= si_r && on;
        end
    end

    // free-bus detector on the selected bit-rate source
    sbs_free_timer u_free (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .timer_ovf_in (timer_ovf_in),
        .src_sel_in   (cfg_r.src_sel),
        .enable_in    (on && cfg_r.fto_en),
        .bus_high_in  (pin_r.scl && pin_r.sda),
        .free_out     (free_pulse)
    );

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_ADDR_VEC: assert property (addr_hit && !lost_ev && !lost_pend_r |=> vec_r == VEC_ADDR && si_r && !arb_r)
        else $error("address match did not report 0010 clear");
    AST_LOST_ADDR: assert property (addr_hit && !lost_ev && lost_pend_r |=> vec_r == VEC_ADDR && arb_r)
        else $error("address after lost arbitration not flagged");
    AST_STOP_VEC: assert property (stop_ev && !lost_ev |=> vec_r == VEC_STOP && !arb_r && si_r)
        else $error("stop while addressed not reported 0001");
    AST_LOST_TRYSTP: assert property (lost_ev && lost_kind_in == LOST_TRYSTP |=> vec_r == VEC_STOP && arb_r)
        else $error("lost stop attempt not reported");
    AST_DATA_VEC: assert property (data_end && !lost_ev |=> vec_r == VEC_DATA && data_r == $past(shift_r))
        else $error("received byte not reported 0000");
    AST_LOST_RSTART: assert property (lost_ev && lost_kind_in == LOST_RSTART |=> vec_r == VEC_ADDR && arb_r)
        else $error("lost repeated start not reported");
    AST_LOST_DETSTP: assert property (lost_ev && lost_kind_in == LOST_DETSTP |=> vec_r == VEC_STOP && arb_r)
        else $error("lost on detected stop not reported");
    AST_LOST_DATA: assert property (lost_ev && lost_kind_in == LOST_DATA |=> vec_r == VEC_DATA && arb_r)
        else $error("lost data byte not reported");
    AST_ACK_REQUEST_FLAG_ZERO: assert property (wb_ack_out && $past(hit_ctl) |-> !wb_dat_out[CTL_ACK_REQUEST_FLAG])
        else $error("acknowledge request flag read nonzero");
    AST_DISABLED: assert property (!on |=> state_r == ST_IDLE && !scl_oe_out && !sda_oe_out)
        else $error("disabled interface still active");
    AST_INHIBIT: assert property (cfg_r.inhibit && !lost_ev && state_r == ST_ADDR |=> !$rose(si_r))
        else $error("slave event raised flag while inhibited");
    AST_BUSY_CLR: assert property (stop_d || free_pulse |=> !busy_r)
        else $error("busy not cleared");
    AST_HOLD: assert property ($rose(si_r) && on |=> scl_oe_out [*2])
        else $error("clock not held after status update");

    COV_ADDR: cover property (addr_hit ##[1:200] data_end);
    COV_LOST_ADDR: cover property (lost_ev ##[1:500] addr_hit);
    COV_STOP: cover property (stop_ev);
    COV_FREE: cover property (busy_r ##1 free_pulse);
endmodule

// ### tb/sbs_bus_master_model.sv
// two-wire bus master model that drives the shared clock and data lines
`timescale 1ns/1ps
module sbs_bus_master_model
(
    input  wire logic sys_clk_in,
    input  wire logic scl_line_in,
    input  wire logic sda_line_in,
    output logic      scl_drv_out,
    output logic      sda_drv_out
);
    // released lines float high through the pull-ups
    initial
    begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
    end

    // half of the 400 ns link clock period
    task automatic half();
        repeat (4) @(posedge sys_clk_in);
    endtask

    // one bit, honouring clock stretching by the slave
    task automatic clk_bit(input logic b, output logic seen);
        int n;
        begin
            sda_drv_out <= b;
            half();
            scl_drv_out <= 1'b1;
            n = 0;
            do
            begin
                @(negedge sys_clk_in);
                n++;
            end
            while (scl_line_in !== 1'b1 && n < 4000);
            seen = sda_line_in;
            half();
            scl_drv_out <= 1'b0;
        end
    endtask

    // start condition: data falls while clock is high
    task automatic start();
        sda_drv_out <= 1'b0;
        half();
        scl_drv_out <= 1'b0;
        half();
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        begin
            for (int i = 7; i >= 0; i--)
                clk_bit(d[i], s);
            clk_bit(1'b1, ack_n);
        end
    endtask

    // stop condition: data rises while clock is high
    task automatic stop();
        sda_drv_out <= 1'b0;
        half();
        scl_drv_out <= 1'b1;
        half();
        sda_drv_out <= 1'b1;
        half();
    endtask

    // leave both lines high without a stop
    task automatic idle_lines();
        sda_drv_out <= 1'b1;
        half();
        scl_drv_out <= 1'b1;
        half();
    endtask
endmodule

// ### tb/tb.sv
// testbench for the two-wire slave status block
`timescale 1ns/1ps
module tb;
    import sbs_pkg::*;
    logic             sys_clk_in   = 1'b0;
    logic             rst_n_in     = 1'b0;
    logic             wb_cyc_in    = 1'b0;
    logic             wb_stb_in    = 1'b0;
    logic             wb_we_in     = 1'b0;
    logic [ADR_W-1:0] wb_adr_in    = '0;
    logic [3:0]       wb_sel_in    = 4'h1;
    logic [31:0]      wb_dat_in    = 32'h0;
    logic [3:0]       timer_ovf_in = 4'h0;
    logic             lost_in      = 1'b0;
    logic [1:0]       lost_kind_in = 2'h0;
    logic [31:0]      wb_dat_out;
    logic             wb_ack_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
    logic             start_request_out, stop_request_out, irq_out, scl_drv, sda_drv;
    int               failures     = 0;
    int               total_checks = 0;
    // open-drain lines with pull-ups
    wire              scl_in       = scl_drv & ~scl_oe_out;
    wire              sda_in       = sda_drv & ~sda_oe_out;

    sbs_slave_status u_sbs_slave_status
    (
        .sys_clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .scl_in, .scl_out, .scl_oe_out, .sda_in,
        .sda_out, .sda_oe_out, .timer_ovf_in, .lost_in, .lost_kind_in, .start_request_out,
        .stop_request_out, .irq_out
    );

    sbs_bus_master_model u_sbs_bus_master_model
    (
        .sys_clk_in,
        .scl_line_in (scl_in),
        .sda_line_in (sda_in),
        .scl_drv_out (scl_drv),
        .sda_drv_out (sda_drv)
    );

    // 20 MHz clock
    initial
    begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        begin
            wb_cyc_in <= 1'b1;
            wb_stb_in <= 1'b1;
            wb_we_in  <= we;
            wb_adr_in <= a;
            wb_dat_in <= {24'h0, d};
            n = 0;
            // ack and read data are taken at the rising edge that samples ack high
            do
            begin
                @(posedge sys_clk_in);
                n++;
            end
            while (wb_ack_out !== 1'b1 && n < 50);
            q = wb_dat_out[7:0];
            check(8'(n < 50), 8'h01);
            wb_cyc_in <= 1'b0;
            wb_stb_in <= 1'b0;
            @(posedge sys_clk_in);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] q;
        begin
            wb(1'b0, a, 8'h00, q);
            check(q, exp);
        end
    endtask

    // wait for the interrupt, judge vector and flags, then release the bus
    task automatic svc(input logic [3:0] vec, input logic arb);
        logic [7:0] q;
        int n;
        begin
            n = 0;
            while (irq_out !== 1'b1 && n < 3000)
            begin
                @(posedge sys_clk_in);
                n++;
            end
            check(irq_out, 1'b1);
            rd(10'h310, {4'h0, vec});
            check(scl_oe_out, 1'b1);
            check({6'h00, scl_out, sda_out}, 8'h00);
            wb(1'b0, 10'h300, 8'h00, q);
            check(q & 8'h0d, {5'h0, arb, 2'h1});
            wr(10'h300, 8'h02);
            wr(10'h314, 8'hff);
            check(irq_out, 1'b0);
        end
    endtask

    task automatic pulse_lost(input logic [1:0] k);
        lost_in      <= 1'b1;
        lost_kind_in <= k;
        @(posedge sys_clk_in);
        lost_in      <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    task automatic pulse_ovf(input logic [3:0] v, input int cnt);
        repeat (cnt)
        begin
            timer_ovf_in <= v;
            @(posedge sys_clk_in);
            timer_ovf_in <= 4'h0;
            @(posedge sys_clk_in);
        end
    endtask

    task automatic test_regs();
        rd(10'h304, 8'h00);
        rd(10'h3fc, 8'h00);
        wr(10'h304, 8'hff);
        rd(10'h304, 8'hdf);
        wr(10'h304, 8'h80);
        wr(10'h30c, 8'h2a);
    endtask

    // every kind of arbitration loss, masked first
    task automatic test_lost();
        wr(10'h318, 8'h00);
        pulse_lost(2'h0);
        repeat (4) @(posedge sys_clk_in);
        check(irq_out, 1'b0);
        wr(10'h318, 8'h01);
        check(irq_out, 1'b1);
        svc(VEC_DATA, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            pulse_lost(2'(k));
            svc((k == 1) ? VEC_ADDR : (k == 0) ? VEC_DATA : VEC_STOP, 1'b1);
            wr(10'h300, 8'h30);
            check(start_request_out, 1'b1);
            check(stop_request_out, 1'b1);
            wr(10'h300, 8'h00);
            check(stop_request_out, 1'b0);
        end
    endtask

    // addressed write of two bytes, then stop
    task automatic test_xfer(input logic arb);
        logic a;
        fork
            begin
                u_sbs_bus_master_model.start();
                u_sbs_bus_master_model.send_byte(8'h54, a);
                check(a, 1'b0);
                u_sbs_bus_master_model.send_byte(8'h5a, a);
                check(a, 1'b0);
                u_sbs_bus_master_model.send_byte(8'ha5, a);
                u_sbs_bus_master_model.stop();
            end
            begin
                svc(VEC_ADDR, arb);
                rd(10'h304, 8'ha0);
                svc(VEC_DATA, 1'b0);
                rd(10'h308, 8'h5a);
                svc(VEC_DATA, 1'b0);
                rd(10'h308, 8'ha5);
                svc(VEC_STOP, 1'b0);
                rd(10'h304, 8'h80);
            end
        join
    endtask

    // addressed read: acknowledged, then ignored until stop
    task automatic test_read();
        logic a;
        fork
            begin
                u_sbs_bus_master_model.start();
                u_sbs_bus_master_model.send_byte(8'h55, a);
                check(a, 1'b0);
                u_sbs_bus_master_model.stop();
            end
            begin
                svc(VEC_ADDR, 1'b0);
                svc(VEC_STOP, 1'b0);
            end
        join
    endtask

    // disabled or inhibited: no answer to own address
    task automatic test_ignore();
        logic a;
        for (int i = 0; i < 2; i++)
        begin
            wr(10'h304, (i == 1) ? 8'hc0 : 8'h00);
            u_sbs_bus_master_model.start();
            u_sbs_bus_master_model.send_byte(8'h54, a);
            check(a, 1'b1);
            u_sbs_bus_master_model.stop();
            repeat (8) @(posedge sys_clk_in);
            check(irq_out, 1'b0);
        end
        pulse_lost(2'h0);
        svc(VEC_DATA, 1'b1);
        wr(10'h304, 8'h80);
    endtask

    // busy cleared by free timeout on each source
    task automatic test_free();
        logic a;
        for (int s = 0; s < 4; s++)
        begin
            wr(10'h304, 8'h84 | 8'(s));
            u_sbs_bus_master_model.start();
            u_sbs_bus_master_model.send_byte(8'h22, a);
            u_sbs_bus_master_model.idle_lines();
            rd(10'h304, 8'ha4 | 8'(s));
            pulse_ovf(~(4'h1 << s), 11);
            pulse_ovf(4'h1 << s, 10);
            rd(10'h304, 8'ha4 | 8'(s));
            pulse_ovf(4'h1 << s, 1);
            repeat (4) @(posedge sys_clk_in);
            rd(10'h304, 8'h84 | 8'(s));
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial
    begin
        #2000000;
        failures++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        test_regs();
        test_lost();
        test_xfer(1'b1);
        test_xfer(1'b0);
        test_read();
        test_ignore();
        test_free();
        stop_test();
    end
endmodule
